// file: logic/clockgen_params.svh
// Purpose: Constants for the clock generator SMBus configuration bank.
// Assumes: Register indices 0 to 4; bus pins sampled on the 10 MHz core clock.
// Notes: Reset values are whole bytes; the masks mark the bits software may change.
`ifndef CLOCKGEN_PARAMS_SVH
`define CLOCKGEN_PARAMS_SVH

`define REG_IDX_OUT_EN 8'h00
`define REG_IDX_SPREAD 8'h01
`define REG_IDX_SLEW 8'h02
`define REG_IDX_REFOUT 8'h03
`define REG_IDX_RSVD4 8'h04
`define REG_COUNT 5

`define RST_OUT_EN 8'h0F
`define RST_SPREAD 8'h06
`define RST_SLEW 8'hFF
`define RST_REFOUT 8'h5F
`define RST_RSVD4 8'h40

`define WMASK_OUT_EN 8'h0F
`define WMASK_SPREAD 8'h3B
`define WMASK_SLEW 8'h0F
`define WMASK_REFOUT 8'hF0

`define SLAVE_ADDR_HI 5'h1A
`define SLAVE_ADDR_LO 1'b0
`define BLOCK_READ_COUNT 8'h08
`define BYTE_LAST_BIT 4'h8
`define SDA_DRIVE_LEVEL 1'b0

`define SPREAD_RB_HI 7
`define SPREAD_RB_LO 6
`define SPREAD_SW_SEL 5
`define SPREAD_AMT_HI 4
`define SPREAD_AMT_LO 3
`define AMP_HI 1
`define AMP_LO 0
`define REF_SLEW_HI 7
`define REF_SLEW_LO 6
`define REF_PD_RUN 5
`define REF_OE 4

`define STRAP_LOW 2'h0
`define STRAP_MID 2'h1
`define RB_OFF 2'h0
`define RB_MID 2'h2
`define RB_HIGH 2'h3
`define DIS_HIZ 2'h1
`define DIS_HIGH 2'h3

`endif

// file: logic/clockgen_pkg.sv
// Purpose: Shared types for the clock generator SMBus configuration bank.
// Assumes: Included constants header defines the numeric values.
// Notes: Types only; numbers live in the params header.
package clockgen_pkg;

	// Transaction phases of the slave controller.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INDEX = 3'b010,
		ST_COUNT = 3'b011,
		ST_WDATA = 3'b100,
		ST_RCOUNT = 3'b101,
		ST_RDATA = 3'b110,
		ST_IGNORE = 3'b111
	} ctrl_state_e;

	// Spread amount applied to the PLL.
	typedef enum logic [1:0] {
		SPREAD_OFF = 2'b00,
		SPREAD_QUARTER = 2'b01,
		SPREAD_HALF = 2'b10
	} spread_amount_e;

endpackage

// file: logic/smbus_byte_if.sv
// Purpose: Byte-level link between the SMBus bit engine and the register controller.
// Assumes: Single clock domain; pulses last one cycle.
// Notes: The engine owns the pins; the controller owns protocol decisions.
`timescale 1ns/100ps
interface smbus_byte_if;
	logic start_p; // Start or repeated start seen.
	logic stop_p; // Stop seen.
	logic rx_p; // Eighth bit of a byte taken.
	logic [7:0] rx_byte; // Byte just received.
	logic ack_p; // Ninth clock of a byte taken.
	logic ack_nack; // Level on the data line during that ninth clock.
	logic ack_en; // Controller wants the current byte acked.
	logic tx_mode; // Controller is sending the next byte.
	logic [7:0] tx_byte; // Byte the controller sends.

	modport engine (output start_p, stop_p, rx_p, rx_byte, ack_p, ack_nack,
		input ack_en, tx_mode, tx_byte);
	modport ctrl (input start_p, stop_p, rx_p, rx_byte, ack_p, ack_nack,
		output ack_en, tx_mode, tx_byte);
endinterface

// file: logic/smbus_bit_engine.sv
// Purpose: SMBus slave bit engine: start/stop detection, byte shifting, ack and data drive.
// Assumes: Bus pins are synchronous to clk_i and slow against it.
// Notes: Drive changes only on a falling clock line, so data is steady while it is high.
`timescale 1ns/100ps
`include "clockgen_params.svh"
module smbus_bit_engine (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic scl_i, // Bus clock level.
	input wire logic sda_i, // Bus data level.
	output logic sda_o, // Level driven when enabled.
	output logic sda_oe_o, // High while pulling the data line.
	smbus_byte_if.engine bus // Byte-level side.
);
	logic scl_reg;
	logic sda_reg;
	logic active_reg;
	logic active_next;
	logic [3:0] bitcnt_reg;
	logic [3:0] bitcnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic drive_reg;
	logic drive_next;
	logic scl_rise;
	logic scl_fall;
	logic in_ack_slot;

	// Edge and condition detection on the sampled pins.
	assign scl_rise = scl_i & ~scl_reg;
	assign scl_fall = ~scl_i & scl_reg;
	assign bus.start_p = scl_i & scl_reg & sda_reg & ~sda_i;
	assign bus.stop_p = scl_i & scl_reg & ~sda_reg & sda_i;
	assign in_ack_slot = (bitcnt_reg == `BYTE_LAST_BIT);
	assign bus.rx_p = active_reg & scl_rise & (bitcnt_reg == `BYTE_LAST_BIT - 4'h1);
	assign bus.rx_byte = {shift_reg[6:0], sda_i};
	assign bus.ack_p = active_reg & scl_rise & in_ack_slot;
	assign bus.ack_nack = sda_i;
	assign sda_o = `SDA_DRIVE_LEVEL;
	assign sda_oe_o = drive_reg;

	// Bit counting and shifting; a start always restarts the byte framing.
	always_comb
	begin
		active_next = active_reg;
		bitcnt_next = bitcnt_reg;
		shift_next = shift_reg;
		drive_next = drive_reg;
		if (bus.start_p)
		begin
			active_next = 1'b1;
			bitcnt_next = 4'h0;
			drive_next = 1'b0;
		end
		else if (bus.stop_p)
		begin
			active_next = 1'b0;
			drive_next = 1'b0;
		end
		else if (active_reg && scl_rise)
		begin
			shift_next = {shift_reg[6:0], sda_i};
			bitcnt_next = in_ack_slot ? 4'h0 : bitcnt_reg + 4'h1;
		end
		else if (active_reg && scl_fall)
		begin
			if (in_ack_slot)
				drive_next = bus.ack_en;
			else
				drive_next = bus.tx_mode & ~bus.tx_byte[3'(7 - bitcnt_reg)];
		end
	end

	// State registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			active_reg <= 1'b0;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			drive_reg <= 1'b0;
		end
		else
		begin
			scl_reg <= scl_i;
			sda_reg <= sda_i;
			active_reg <= active_next;
			bitcnt_reg <= bitcnt_next;
			shift_reg <= shift_next;
			drive_reg <= drive_next;
		end
	end
endmodule // smbus_bit_engine

// file: logic/clockgen_smbus_config_regs.sv
// Purpose: SMBus configuration bank for a four-output differential clock generator.
// Assumes: Pins synchronous to clk_i; disable state and power-down come from outside.
// Notes: Only indices 0 to 4 are held here; other indices read as zero.
`timescale 1ns/100ps
`include "clockgen_params.svh"
module clockgen_smbus_config_regs (
	input wire logic clk_i, // Core clock, 10 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic scl_i, // SMBus clock.
	input wire logic sda_i, // SMBus data in.
	output logic sda_o, // SMBus data out level.
	output logic sda_oe_o, // SMBus data pull enable.
	input wire logic address_strap_pin_i, // Variable address bit strap.
	input wire logic [1:0] spread_strap_i, // Tri-level strap: 0 low, 1 mid, 2 high.
	input wire logic [3:0] diff_out_en_n_i, // Per-output enable pins, active low.
	input wire logic [1:0] disable_state_field_i, // Disable state selection.
	input wire logic power_down_i, // Device in power-down.
	output logic [3:0] diff_out_run_o, // 1 runs the output, 0 holds disable state.
	output logic [3:0] diff_out_slew_fast_o, // Per-output slew, 1 fast.
	output logic [1:0] diff_amplitude_o, // Amplitude code.
	output logic [1:0] spread_amount_o, // Applied spread amount.
	output logic [1:0] refout_slew_field_o, // Reference slew code.
	output logic refout_run_o, // Reference output toggling.
	output logic refout_oe_o, // Reference pad driven.
	output logic refout_level_o // Reference level while disabled.
);
	smbus_byte_if link ();
	clockgen_pkg::ctrl_state_e state_reg;
	clockgen_pkg::ctrl_state_e state_next;
	logic [7:0] out_en_reg;
	logic [7:0] spread_reg;
	logic [7:0] slew_reg;
	logic [7:0] refout_reg;
	logic [1:0] strap_rb_reg;
	logic addr_bit_reg;
	logic [7:0] ptr_reg;
	logic [7:0] ptr_next;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic ack_reg;
	logic ack_next;
	logic wr_en;
	logic addr_match;
	logic [7:0] rd_data;
	logic [1:0] spread_sel;
	logic ref_run;
	logic [3:0] diff_run;

	// Keep software-writable bits, leave reserved bits at their power-up value.
	function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] data,
		input logic [7:0] mask);
		masked_write = (old & ~mask) | (data & mask);
	endfunction

	// Map a software or readback spread code to the applied amount.
	function automatic logic [1:0] spread_decode(input logic [1:0] code, input logic sw);
		if (sw)
			spread_decode = (code == 2'b01) ? clockgen_pkg::SPREAD_QUARTER :
				(code == 2'b11) ? clockgen_pkg::SPREAD_HALF : clockgen_pkg::SPREAD_OFF;
		else
			spread_decode = (code == `RB_MID) ? clockgen_pkg::SPREAD_QUARTER :
				(code == `RB_HIGH) ? clockgen_pkg::SPREAD_HALF : clockgen_pkg::SPREAD_OFF;
	endfunction

	smbus_bit_engine engine_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.bus(link.engine)
	);

	// Address compare and read data selection.
	assign addr_match = (link.rx_byte[7:1] == {`SLAVE_ADDR_HI, addr_bit_reg, `SLAVE_ADDR_LO});
	assign rd_data = (ptr_reg == `REG_IDX_OUT_EN) ? out_en_reg :
		(ptr_reg == `REG_IDX_SPREAD) ? {strap_rb_reg, spread_reg[5:0]} :
		(ptr_reg == `REG_IDX_SLEW) ? slew_reg :
		(ptr_reg == `REG_IDX_REFOUT) ? refout_reg :
		(ptr_reg == `REG_IDX_RSVD4) ? `RST_RSVD4 : 8'h00;
	assign link.tx_mode = (state_reg == clockgen_pkg::ST_RCOUNT) ||
		(state_reg == clockgen_pkg::ST_RDATA);
	assign link.tx_byte = (state_reg == clockgen_pkg::ST_RCOUNT) ? `BLOCK_READ_COUNT : rd_data;
	assign link.ack_en = ack_reg;
	assign wr_en = link.rx_p && (state_reg == clockgen_pkg::ST_WDATA) && (count_reg != 8'h00) &&
		(ptr_reg < 8'(`REG_COUNT));

	// Protocol sequencing for block write and block read.
	always_comb
	begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		count_next = count_reg;
		ack_next = ack_reg;
		if (link.start_p)
		begin
			state_next = clockgen_pkg::ST_ADDR;
			ack_next = 1'b0;
		end
		else if (link.stop_p)
		begin
			state_next = clockgen_pkg::ST_IDLE;
			ack_next = 1'b0;
		end
		else if (link.ack_p)
		begin
			ack_next = 1'b0;
			// The address ack also ends in the count state, with our own pull still flagged.
			// Only the host's answer to the count byte may move on, or the count is skipped.
			if (link.tx_mode && link.ack_nack)
				state_next = clockgen_pkg::ST_IGNORE;
			else if ((state_reg == clockgen_pkg::ST_RCOUNT) && !ack_reg)
				state_next = clockgen_pkg::ST_RDATA;
			else if (state_reg == clockgen_pkg::ST_RDATA)
				ptr_next = ptr_reg + 8'h01;
		end
		else if (link.rx_p)
		begin
			ack_next = 1'b1;
			case (state_reg)
				clockgen_pkg::ST_ADDR:
				begin
					ack_next = addr_match;
					if (!addr_match)
						state_next = clockgen_pkg::ST_IGNORE;
					else if (link.rx_byte[0])
						state_next = clockgen_pkg::ST_RCOUNT;
					else
						state_next = clockgen_pkg::ST_INDEX;
				end
				clockgen_pkg::ST_INDEX:
				begin
					ptr_next = link.rx_byte;
					state_next = clockgen_pkg::ST_COUNT;
				end
				clockgen_pkg::ST_COUNT:
				begin
					count_next = link.rx_byte;
					state_next = clockgen_pkg::ST_WDATA;
				end
				clockgen_pkg::ST_WDATA:
				begin
					if (count_reg != 8'h00)
						count_next = count_reg - 8'h01;
					if (ptr_reg != 8'hFF)
						ptr_next = ptr_reg + 8'h01;
				end
				clockgen_pkg::ST_RCOUNT, clockgen_pkg::ST_RDATA, clockgen_pkg::ST_IGNORE,
				clockgen_pkg::ST_IDLE:
					ack_next = 1'b0;
				default:
					ack_next = 1'b0;
			endcase
		end
	end

	// Controller state.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= clockgen_pkg::ST_IDLE;
			ptr_reg <= 8'h00;
			count_reg <= 8'h00;
			ack_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ptr_reg <= ptr_next;
			count_reg <= count_next;
			ack_reg <= ack_next;
		end
	end

	// Straps are caught while reset is held, so they stay put afterwards.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			addr_bit_reg <= address_strap_pin_i;
			strap_rb_reg <= (spread_strap_i == `STRAP_LOW) ? `RB_OFF :
				(spread_strap_i == `STRAP_MID) ? `RB_MID : `RB_HIGH;
		end
	end

	// Configuration registers, written one byte per received data byte.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_en_reg <= `RST_OUT_EN;
			spread_reg <= `RST_SPREAD;
			slew_reg <= `RST_SLEW;
			refout_reg <= `RST_REFOUT;
		end
		else if (wr_en)
		begin
			if (ptr_reg == `REG_IDX_OUT_EN)
				out_en_reg <= masked_write(out_en_reg, link.rx_byte, `WMASK_OUT_EN);
			if (ptr_reg == `REG_IDX_SPREAD)
				spread_reg <= masked_write(spread_reg, link.rx_byte, `WMASK_SPREAD);
			if (ptr_reg == `REG_IDX_SLEW)
				slew_reg <= masked_write(slew_reg, link.rx_byte, `WMASK_SLEW);
			if (ptr_reg == `REG_IDX_REFOUT)
				refout_reg <= masked_write(refout_reg, link.rx_byte, `WMASK_REFOUT);
		end
	end

	// Effective controls derived from the registers and the pins.
	assign diff_run = out_en_reg[3:0] & ~diff_out_en_n_i;
	assign spread_sel = spread_reg[`SPREAD_SW_SEL] ?
		spread_reg[`SPREAD_AMT_HI:`SPREAD_AMT_LO] : strap_rb_reg;
	assign ref_run = refout_reg[`REF_OE] & (~power_down_i | refout_reg[`REF_PD_RUN]);

	// Outputs are registered so the analog side sees clean levels.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			diff_out_run_o <= 4'h0;
			diff_out_slew_fast_o <= 4'(`RST_SLEW);
			diff_amplitude_o <= 2'(`RST_SPREAD);
			spread_amount_o <= clockgen_pkg::SPREAD_OFF;
			refout_slew_field_o <= 2'(`RST_REFOUT >> `REF_SLEW_LO);
			refout_run_o <= 1'b0;
			refout_oe_o <= 1'b0;
			refout_level_o <= 1'b0;
		end
		else
		begin
			diff_out_run_o <= diff_run;
			diff_out_slew_fast_o <= slew_reg[3:0];
			diff_amplitude_o <= spread_reg[`AMP_HI:`AMP_LO];
			spread_amount_o <= spread_decode(spread_sel, spread_reg[`SPREAD_SW_SEL]);
			refout_slew_field_o <= refout_reg[`REF_SLEW_HI:`REF_SLEW_LO];
			refout_run_o <= ref_run;
			refout_oe_o <= ref_run | (disable_state_field_i != `DIS_HIZ);
			refout_level_o <= ~ref_run & (disable_state_field_i == `DIS_HIGH);
		end
	end
endmodule // clockgen_smbus_config_regs

// file: sim/clockgen_regs_chk.sv
// Purpose: Port-level checks of the SMBus configuration bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Outputs lag their causes by one cycle, so causes are read with $past.
`timescale 1ns/100ps
module clockgen_regs_chk (
	input wire logic clk_i, // Clock.
	input wire logic rst_i, // Reset.
	input wire logic scl_i, // Bus clock.
	input wire logic sda_o, // Data level.
	input wire logic sda_oe_o, // Data pull.
	input wire logic [3:0] diff_out_en_n_i, // Enable pins.
	input wire logic [1:0] disable_state_field_i, // Disable state.
	input wire logic [3:0] diff_out_run_o, // Output run.
	input wire logic [3:0] diff_out_slew_fast_o, // Slew.
	input wire logic [1:0] diff_amplitude_o, // Amplitude.
	input wire logic [1:0] spread_amount_o, // Spread.
	input wire logic [1:0] refout_slew_field_o, // Ref slew.
	input wire logic refout_run_o, // Ref running.
	input wire logic refout_oe_o, // Ref driven.
	input wire logic refout_level_o // Ref level.
);
	// All checks share the core clock and stay quiet while reset is held.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// The data pin may only pull low, and may only start or stop pulling while the bus clock is low.
	open_drain_a: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	ack_in_low_a: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
		else $error("data pull began while bus clock high");
	ack_release_a: assert property ($fell(sda_oe_o) |-> !scl_i)
		else $error("data pull ended while bus clock high");
	// Reset values are still visible at the first edge after release.
	reset_values_a: assert property ($fell(rst_i) |-> diff_amplitude_o == 2'h2 &&
		diff_out_slew_fast_o == 4'hF && refout_slew_field_o == 2'h1)
		else $error("power-up output codes wrong");
	pin_override_a: assert property ((diff_out_run_o & $past(diff_out_en_n_i)) == 4'h0)
		else $error("output runs with its enable pin high");
	ref_run_driven_a: assert property (refout_run_o |-> refout_oe_o)
		else $error("running reference not driven");
	// The disabled reference follows the disable-state field of the previous cycle.
	ref_float_a: assert property (!refout_run_o && !$past(rst_i) &&
		$past(disable_state_field_i) == 2'h1 |-> !refout_oe_o)
		else $error("disabled reference not floating");
	ref_high_a: assert property (!refout_run_o && !$past(rst_i) &&
		$past(disable_state_field_i) == 2'h3 |-> refout_oe_o && refout_level_o)
		else $error("disabled reference not high");
	ref_low_a: assert property (!refout_run_o && !$past(rst_i) &&
		!$past(disable_state_field_i[0]) |-> refout_oe_o && !refout_level_o)
		else $error("disabled reference not low");
	spread_codes_a: assert property (spread_amount_o != 2'h3)
		else $error("unknown spread code");
	cover property ($rose(sda_oe_o));
	cover property (!refout_run_o && refout_level_o);
	cover property (spread_amount_o == 2'h2);
endmodule // clockgen_regs_chk

bind clockgen_smbus_config_regs clockgen_regs_chk u_chk (.clk_i, .rst_i, .scl_i, .sda_o,
	.sda_oe_o, .diff_out_en_n_i, .disable_state_field_i, .diff_out_run_o,
	.diff_out_slew_fast_o, .diff_amplitude_o, .spread_amount_o, .refout_slew_field_o,
	.refout_run_o, .refout_oe_o, .refout_level_o);

// file: sim/smbus_host_model.sv
// Purpose: Behavioural SMBus host framing block reads and writes.
// Assumes: Tasks are called from the bench; lines change on falling clk edges.
// Notes: Each bit's bus clock phase lasts four core clocks, above the slave's minimum.
`timescale 1ns/100ps
module smbus_host_model (
	input wire logic clk_i, // Core clock.
	input wire logic sda_i, // Resolved data line.
	output logic scl_o, // Bus clock.
	output logic sda_o // Data, 1 releases.
);
	// Idle bus: both lines released high.
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic h(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Data moves a cycle after the clock falls, so it never moves while high.
	task automatic bit_out(input logic b);
		h(1);
		sda_o = b;
		h(3);
		scl_o = 1'b1;
		h(4);
		scl_o = 1'b0;
	endtask
	task automatic bit_in(output logic b);
		h(1);
		sda_o = 1'b1;
		h(3);
		scl_o = 1'b1;
		h(2);
		b = sda_i;
		h(2);
		scl_o = 1'b0;
	endtask
	// Start and repeated start share one shape: data falls while the clock is high.
	task automatic start();
		h(1);
		sda_o = 1'b1;
		h(3);
		scl_o = 1'b1;
		h(4);
		sda_o = 1'b0;
		h(4);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		h(1);
		sda_o = 1'b0;
		h(3);
		scl_o = 1'b1;
		h(4);
		sda_o = 1'b1;
		h(4);
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic nb;
		for (int i = 7; i >= 0; i--)
			bit_out(b[i]);
		bit_in(nb);
		ack = !nb;
	endtask
	// Every read byte is acked except the last, which gets a not-acknowledge.
	task automatic rd_byte(output logic [7:0] b, input logic last);
		for (int i = 7; i >= 0; i--)
			bit_in(b[i]);
		bit_out(last);
	endtask
endmodule // smbus_host_model

// file: sim/clockgen_smbus_config_regs_bench.sv
// Purpose: Self-checking bench for the SMBus configuration bank.
// Assumes: Straps start high address (0xD4) and mid spread; a second reset changes both.
// Notes: A shadow copy of the bank is updated through the writable-bit masks.
`timescale 1ns/100ps
module clockgen_smbus_config_regs_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] en_n = 4'h0;
	logic [1:0] field = 2'h0;
	logic pd = 1'b0;
	logic strap_a = 1'b1;
	logic [1:0] strap_s = 2'h1;
	logic [7:0] dev = 8'hD4;
	logic scl, sda_host, sda_oe, sda_dev, ack, rrun, roe, rlvl;
	logic [3:0] run, slew;
	logic [1:0] amp, spread, rslew;
	logic [7:0] rb;
	logic [7:0] shadow [0:4] = '{8'h0F, 8'h86, 8'hFF, 8'h5F, 8'h40};
	logic [7:0] wbuf [0:5];
	int num_errors = 0;
	int compares = 0;
	// Open-drain data line with a pull-up: low when either side pulls.
	wire sda = sda_host & ~(sda_oe & ~sda_dev);
	initial forever #50 clk_i = ~clk_i;
	smbus_host_model u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_host));
	clockgen_smbus_config_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_dev), .sda_oe_o(sda_oe), .address_strap_pin_i(strap_a),
		.spread_strap_i(strap_s),
		.diff_out_en_n_i(en_n), .disable_state_field_i(field), .power_down_i(pd),
		.diff_out_run_o(run), .diff_out_slew_fast_o(slew), .diff_amplitude_o(amp),
		.spread_amount_o(spread), .refout_slew_field_o(rslew), .refout_run_o(rrun),
		.refout_oe_o(roe), .refout_level_o(rlvl));
	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic send(input logic [7:0] b);
		u_host.wr_byte(b, ack);
		chk("ack", 8'h01, {7'h0, ack});
	endtask
	function automatic logic [7:0] wmask(input int i);
		return i == 0 ? 8'h0F : i == 1 ? 8'h3B : i == 2 ? 8'h0F : i == 3 ? 8'hF0 : 8'h00;
	endfunction
	// Bytes past index 4 are sent but leave the shadow untouched.
	task automatic blk_wr(input int idx, input int n);
		u_host.start();
		send(dev);
		send(8'(idx));
		send(8'(n));
		for (int i = 0; i < n; i++)
		begin
			send(wbuf[i]);
			if (idx + i < 5)
				shadow[idx+i] = (shadow[idx+i] & ~wmask(idx+i)) | (wbuf[i] & wmask(idx+i));
		end
		u_host.stop();
	endtask
	task automatic blk_rd(input int idx, input int n);
		u_host.start();
		send(dev);
		send(8'(idx));
		u_host.start();
		send(dev | 8'h01);
		u_host.rd_byte(rb, 1'b0);
		chk("count", 8'h08, rb);
		for (int i = 0; i < n; i++)
		begin
			u_host.rd_byte(rb, i == n - 1);
			chk("reg", idx + i < 5 ? shadow[idx+i] : 8'h00, rb);
		end
		u_host.stop();
	endtask
	// The reference level only matters while the reference is stopped.
	task automatic outs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		chk("run_slew", a, {run, slew});
		chk("amp_spread_rslew", b, {amp, spread, rslew, 2'h0});
		chk("ref", c, {5'h0, rrun, roe, rlvl & ~rrun});
	endtask
	// Main sequence: power-up, framing, each field, then the reference modes.
	initial
	begin
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		outs(8'hFF, 8'h94, 8'h06);
		blk_rd(0, 5);
		u_host.start();
		u_host.wr_byte(8'hD0, ack);
		chk("foreign_addr", 8'h00, {7'h0, ack});
		u_host.stop();
		u_host.start();
		send(8'hD4);
		send(8'h02);
		u_host.stop();
		wbuf = '{8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'hAA};
		blk_wr(0, 6);
		outs(8'h00, 8'hE0, 8'h02);
		blk_rd(0, 5);
		for (int f = 0; f < 4; f++)
		begin
			field = 2'(f);
			repeat (2) @(negedge clk_i);
			outs(8'h00, 8'hE0, {6'h0, f != 1, f == 3});
		end
		en_n = 4'h5;
		pd = 1'b1;
		wbuf = '{8'h0F, 8'h29, 8'h0A, 8'hF0, 8'h00, 8'h00};
		blk_wr(0, 4);
		outs(8'hAA, 8'h5C, 8'h06);
		wbuf[0] = 8'hD0;
		blk_wr(3, 1);
		outs(8'hAA, 8'h5C, 8'h03);
		pd = 1'b0;
		repeat (2) @(negedge clk_i);
		outs(8'hAA, 8'h5C, 8'h06);
		blk_rd(1, 2);
		// Second reset on an idle bus: address bit low and spread strap high are caught.
		strap_a = 1'b0;
		strap_s = 2'h2;
		rst_i = 1'b1;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		shadow = '{8'h0F, 8'hC6, 8'hFF, 8'h5F, 8'h40};
		outs(8'hAF, 8'hA4, 8'h06);
		dev = 8'hD0;
		blk_rd(1, 1);
		u_host.start();
		u_host.wr_byte(8'hD4, ack);
		chk("old_addr", 8'h00, {7'h0, ack});
		u_host.stop();
		tally_and_finish();
	end
	// A hang is cut short well beyond the few thousand cycles the sequence needs.
	initial
	begin
		repeat (40000) @(posedge clk_i);
		num_errors++;
		tally_and_finish();
	end
endmodule // clockgen_smbus_config_regs_bench
